// File: spi_host_model.sv
// Host side serial master model, clock idle low, most significant bit first.
`timescale 1ns/1ps
module spi_host_model (
   // Link
   output logic sclk_out,
   output logic ncs_out,
   output logic sdi_out,
   input wire logic sdo_in
);
   // ==========================================
   // Frame task
   initial begin
      sclk_out = 1'b0;
      ncs_out = 1'b1;
      sdi_out = 1'b0;
   end
   // A read byte is followed by a slow pause so the device can fetch the word
   // before its first bit must leave; the clock stands low between frames.
   task automatic xfer(input logic [7:0] cb, input logic [15:0] wd, output logic [15:0] rd);
      int n;
      logic [23:0] sh;
      n = cb[7] ? 8 : 24;
      sh = {cb, wd};
      rd = 16'h0000;
      ncs_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdi_out = sh[23 - i];
         #6 sclk_out = 1'b1;
         if (i >= 8) rd = {rd[14:0], sdo_in};
         if (i == 7 && cb[0] && !cb[7]) #100;
         #6 sclk_out = 1'b0;
      end
      #6 ncs_out = 1'b1;
      sdi_out = ~sdi_out;
   endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the control byte decoder.
`timescale 1ns/1ps
module tb_top
   import touch_ctrl_pkg::*;
;
   typedef struct packed {
      logic [7:0] cb;
      logic [3:0] code;
      logic res;
      logic [3:0] drv;
   } row_type;
   // ==========================================
   // Signals
   logic MCLK_IN = 1'b0, NRST_IN = 1'b0, PEN_DOWN_IN = 1'b0, FUNC_DONE_IN = 1'b0;
   logic TEST_PASS_IN = 1'b0, PEN_CONTROL_MODE_IN = 1'b0;
   logic [15:0] REG_RDATA_IN = 16'h3c96;
   wire logic SCLK_IN, NCS_IN, SDI_IN;
   logic SDO_OUT, SDO_OE_OUT, REG_WR_OUT, REG_RD_OUT, FUNC_START_OUT, FUNC_BUSY_OUT;
   logic CONT_MODE_OUT, RESOLUTION_SELECT_OUT, SOFT_RESET_OUT, STOP_OUT, BIAS_KEEP_ON_OUT;
   logic BIAS_ON_OUT, ADC_POWER_OUT, PEN_DATA_INTERRUPT_PIN_OUT;
   logic [3:0] REG_ADDR_OUT, FUNCTION_SELECT_CODE_OUT;
   logic [15:0] REG_WDATA_OUT, CONFIG_REGISTER_ZERO_STATUS_OUT, rd_w;
   drivers_type DRIVERS_OUT;
   int failures = 0, check_count = 0, wr_count = 0, start_count = 0, s0;
   row_type rows [3] = '{'{8'hec, 4'hd, 1'b1, 4'b1100}, '{8'hf0, 4'he, 1'b0, 4'b0011},
      '{8'hfc, 4'hf, 1'b1, 4'b0110}};
   touch_ctrl_byte_decoder touch_ctrl_byte_decoder_i (
      .MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .SCLK_IN(SCLK_IN), .NCS_IN(NCS_IN),
      .SDI_IN(SDI_IN), .SDO_OUT(SDO_OUT), .SDO_OE_OUT(SDO_OE_OUT), .REG_RDATA_IN(REG_RDATA_IN),
      .REG_ADDR_OUT(REG_ADDR_OUT), .REG_WDATA_OUT(REG_WDATA_OUT), .REG_WR_OUT(REG_WR_OUT),
      .REG_RD_OUT(REG_RD_OUT), .PEN_DOWN_IN(PEN_DOWN_IN), .FUNC_DONE_IN(FUNC_DONE_IN),
      .TEST_PASS_IN(TEST_PASS_IN), .PEN_CONTROL_MODE_IN(PEN_CONTROL_MODE_IN),
      .FUNCTION_SELECT_CODE_OUT(FUNCTION_SELECT_CODE_OUT), .FUNC_START_OUT(FUNC_START_OUT),
      .FUNC_BUSY_OUT(FUNC_BUSY_OUT), .CONT_MODE_OUT(CONT_MODE_OUT),
      .RESOLUTION_SELECT_OUT(RESOLUTION_SELECT_OUT), .SOFT_RESET_OUT(SOFT_RESET_OUT),
      .STOP_OUT(STOP_OUT), .BIAS_KEEP_ON_OUT(BIAS_KEEP_ON_OUT), .BIAS_ON_OUT(BIAS_ON_OUT),
      .ADC_POWER_OUT(ADC_POWER_OUT), .DRIVERS_OUT(DRIVERS_OUT),
      .CONFIG_REGISTER_ZERO_STATUS_OUT(CONFIG_REGISTER_ZERO_STATUS_OUT),
      .PEN_DATA_INTERRUPT_PIN_OUT(PEN_DATA_INTERRUPT_PIN_OUT)
   );
   spi_host_model spi_host_model_i (
      .sclk_out(SCLK_IN), .ncs_out(NCS_IN), .sdi_out(SDI_IN), .sdo_in(SDO_OUT)
   );
   always #5 MCLK_IN = ~MCLK_IN;
   always @(posedge MCLK_IN) begin
      wr_count <= wr_count + (REG_WR_OUT ? 1 : 0);
      start_count <= start_count + (FUNC_START_OUT ? 1 : 0);
   end
   // ==========================================
   // Tasks
   task automatic print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Waits a settled eight cycles, past the three to four the decoder needs.
   task automatic send(input logic [7:0] cb, input logic [15:0] wd);
      #3;
      spi_host_model_i.xfer(cb, wd, rd_w);
      repeat (8) @(posedge MCLK_IN);
      #1;
   endtask
   task automatic wait_start;
      int n;
      n = 0;
      while (start_count == s0 && n < 300) begin
         @(posedge MCLK_IN);
         #1;
         n++;
      end
      if (n == 300) begin
         failures++;
         print_verdict;
      end
   endtask
   // ==========================================
   // Sequence
   initial begin
      #900000;
      failures++;
      print_verdict;
   end
   initial begin
      repeat (8) @(posedge MCLK_IN);
      NRST_IN <= 1'b1;
      repeat (3) @(posedge MCLK_IN);
      #1;
      chk(PEN_DATA_INTERRUPT_PIN_OUT, 1'b1);
      chk(CONFIG_REGISTER_ZERO_STATUS_OUT, 16'h4000);
      for (int i = 0; i < 3; i++) begin
         send(rows[i].cb, 16'h0000);
         chk(FUNCTION_SELECT_CODE_OUT, rows[i].code);
         chk(CONFIG_REGISTER_ZERO_STATUS_OUT[13], rows[i].res);
         chk(DRIVERS_OUT, rows[i].drv);
      end
      send(8'h42, 16'ha5c3);
      chk(wr_count, 1);
      chk(REG_WDATA_OUT, 16'ha5c3);
      chk(BIAS_KEEP_ON_OUT, 1'b1);
      send(8'h61, 16'h0000);
      chk(rd_w, 16'h3c96);
      chk(REG_ADDR_OUT, 4'hc);
      chk(wr_count, 1);
      send(8'hc8, 16'h0000);
      chk(PEN_DATA_INTERRUPT_PIN_OUT, 1'b0);
      @(posedge MCLK_IN);
      FUNC_DONE_IN <= 1'b1;
      repeat (10) @(posedge MCLK_IN);
      FUNC_DONE_IN <= 1'b0;
      #1;
      chk(PEN_DATA_INTERRUPT_PIN_OUT, 1'b0);
      send(8'h81, 16'h0000);
      chk(STOP_OUT, 1'b1);
      chk(PEN_DATA_INTERRUPT_PIN_OUT, 1'b1);
      send(8'he0, 16'h0000);
      chk(STOP_OUT, 1'b0);
      TEST_PASS_IN <= 1'b1;
      send(8'hd0, 16'h0000);
      FUNC_DONE_IN <= 1'b1;
      repeat (10) @(posedge MCLK_IN);
      FUNC_DONE_IN <= 1'b0;
      #1;
      chk(PEN_DATA_INTERRUPT_PIN_OUT, 1'b1);
      send(8'h9e, 16'h0000);
      chk(SOFT_RESET_OUT, 1'b1);
      chk(CONFIG_REGISTER_ZERO_STATUS_OUT, 16'h4000);
      send(8'he0, 16'h0000);
      chk(SOFT_RESET_OUT, 1'b0);
      PEN_CONTROL_MODE_IN <= 1'b1;
      send(8'h88, 16'h0000);
      s0 = start_count;
      PEN_DOWN_IN <= 1'b1;
      wait_start;
      chk(FUNCTION_SELECT_CODE_OUT, 4'h1);
      PEN_DOWN_IN <= 1'b0;
      repeat (30) @(posedge MCLK_IN);
      #1;
      chk(FUNC_BUSY_OUT, 1'b0);
      s0 = start_count;
      PEN_DOWN_IN <= 1'b1;
      wait_start;
      send(8'h81, 16'h0000);
      chk(FUNC_BUSY_OUT, 1'b0);
      PEN_CONTROL_MODE_IN <= 1'b0;
      send(8'h88, 16'h0000);
      chk(FUNC_BUSY_OUT, 1'b1);
      PEN_DOWN_IN <= 1'b0;
      repeat (30) @(posedge MCLK_IN);
      PEN_DOWN_IN <= 1'b1;
      repeat (30) @(posedge MCLK_IN);
      #1;
      chk(FUNC_BUSY_OUT, 1'b0);
      print_verdict;
   end
endmodule

// File: touch_ctrl_byte_decoder.sv
// Control byte decoder for a resistive touch controller with an SPI slave link.
`timescale 1ns/1ps
`include "touch_ctrl_cfg.svh"
module touch_ctrl_byte_decoder
   import touch_ctrl_pkg::*;
(
   // System clock and reset
   input wire logic MCLK_IN,
   input wire logic NRST_IN,
   // SPI link
   input wire logic SCLK_IN,
   input wire logic NCS_IN,
   input wire logic SDI_IN,
   output logic SDO_OUT,
   output logic SDO_OE_OUT,
   // Register file side
   input wire logic [15:0] REG_RDATA_IN,
   output logic [3:0] REG_ADDR_OUT,
   output logic [15:0] REG_WDATA_OUT,
   output logic REG_WR_OUT,
   output logic REG_RD_OUT,
   // Analog side status
   input wire logic PEN_DOWN_IN,
   input wire logic FUNC_DONE_IN,
   input wire logic TEST_PASS_IN,
   input wire logic PEN_CONTROL_MODE_IN,
   // Converter control
   output logic [3:0] FUNCTION_SELECT_CODE_OUT,
   output logic FUNC_START_OUT,
   output logic FUNC_BUSY_OUT,
   output logic CONT_MODE_OUT,
   output logic RESOLUTION_SELECT_OUT,
   output logic SOFT_RESET_OUT,
   output logic STOP_OUT,
   output logic BIAS_KEEP_ON_OUT,
   output logic BIAS_ON_OUT,
   output logic ADC_POWER_OUT,
   output drivers_type DRIVERS_OUT,
   output logic [15:0] CONFIG_REGISTER_ZERO_STATUS_OUT,
   output logic PEN_DATA_INTERRUPT_PIN_OUT
);
   // ==========================================
   // Decoding helpers; code_field serves both clock domains, the others the system domain only.
   // The same four bits are a function select code in a start byte and a register
   // address in an access byte, so one helper serves both readings.
   function automatic logic [3:0] code_field(input logic [7:0] cb);
      code_field = cb[`CB_CODE_HI:`CB_CODE_LO];
   endfunction

   // The three panel tests pull the interrupt pin low while they run.
   function automatic logic is_test_code(input logic [3:0] code);
      is_test_code = code == `FN_TEST_X || code == `FN_TEST_Y || code == `FN_TEST_SHORT;
   endfunction

   // Only the two touch scans end on pen lift and may be restarted by a touch.
   function automatic logic is_scan_code(input logic [3:0] code);
      is_scan_code = code == `FN_SCAN_XYZ || code == `FN_SCAN_XY;
   endfunction

   // A start byte has the type bit set; anything else is a register access.
   function automatic logic is_start_byte(input logic [7:0] cb);
      is_start_byte = cb[`CB_TYPE_BIT];
   endfunction

   // Driver pattern for the three driver-only codes; every other code drives nothing.
   function automatic drivers_type drivers_for(input logic [3:0] code);
      unique case (code)
         `FN_DRV_X: drivers_for = 4'b1100;
         `FN_DRV_Y: drivers_for = 4'b0011;
         `FN_DRV_YX: drivers_for = 4'b0110;
         default: drivers_for = 4'b0000;
      endcase
   endfunction

   // ==========================================
   // Link domain: MSB-first shifter, mode 0.
   logic [15:0] shift_q;
   logic [4:0] bit_cnt_q;
   phase_type phase_q;
   logic [7:0] cmd_q;
   logic cmd_tgl_q;
   logic [15:0] word_q;
   logic [3:0] word_addr_q;
   logic word_tgl_q;
   logic [15:0] tx_q;
   logic rd_tgl_q;
   logic [15:0] rdata_hold_q;
   logic [15:0] sh_next;
   assign sh_next = {shift_q[14:0], SDI_IN};

   // The shifter is one word wide so a control byte and a data word share it; the
   // phase tells the two apart. The phase moves to the word only after an access
   // byte, because a start byte carries no data word.
   // Chip select high is asynchronous to the link so frames end without a clock edge.
   always_ff @(posedge SCLK_IN or posedge NCS_IN) begin
      if (NCS_IN) begin
         bit_cnt_q <= 5'h0;
         phase_q <= PH_CMD;
         shift_q <= 16'h0000;
      end else begin
         shift_q <= sh_next;
         if (phase_q == PH_CMD && bit_cnt_q == 5'd7) begin
            bit_cnt_q <= 5'h0;
            if (!sh_next[`CB_TYPE_BIT] && !sh_next[`CB_DIR_BIT]) begin
               phase_q <= PH_WORD;
            end else if (!sh_next[`CB_TYPE_BIT]) begin
               phase_q <= PH_WORD;
            end
         end else if (phase_q == PH_WORD && bit_cnt_q == 5'd15) begin
            bit_cnt_q <= 5'h0;
            phase_q <= PH_CMD;
         end else begin
            bit_cnt_q <= bit_cnt_q + 5'h1;
         end
      end
   end

   // Captured bytes and words are kept under the system reset only, not under chip
   // select, so a completed byte survives the host releasing chip select at once.
   always_ff @(posedge SCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cmd_q <= 8'h00;
         cmd_tgl_q <= 1'b0;
         word_q <= 16'h0000;
         word_addr_q <= 4'h0;
         word_tgl_q <= 1'b0;
      end else if (!NCS_IN) begin
         if (phase_q == PH_CMD && bit_cnt_q == 5'd7) begin
            cmd_q <= sh_next[7:0];
            cmd_tgl_q <= ~cmd_tgl_q;
            word_addr_q <= code_field(sh_next[7:0]);
         end
         if (phase_q == PH_WORD && bit_cnt_q == 5'd15 && !cmd_q[`CB_DIR_BIT]) begin
            word_q <= sh_next;
            word_tgl_q <= ~word_tgl_q;
         end
      end
   end

   // Limitation: the read word is fetched through the system clock domain, which
   // takes about four system cycles after the eighth rising edge. A host that clocks
   // the first read bit sooner sees stale data, so it must pause after a read byte.
   // The register is loaded on the falling edge so its first bit stands half a
   // clock before the host samples it.
   // Read data is sampled from the system side holding register; MSB goes out first.
   always_ff @(negedge SCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         tx_q <= 16'h0000;
      end else if (phase_q == PH_WORD && bit_cnt_q == 5'd0) begin
         tx_q <= rdata_hold_q;
      end else begin
         tx_q <= {tx_q[14:0], 1'b0};
      end
   end
   // The output enable follows chip select directly so the line is released as soon
   // as the host deselects, without waiting for a link clock.
   assign SDO_OUT = tx_q[15];
   assign SDO_OE_OUT = !NCS_IN && phase_q == PH_WORD && cmd_q[`CB_DIR_BIT];

   // ==========================================
   // Crossing into the system domain by toggle synchronisers.
   // Each captured byte or word flips a toggle in the link domain. Only the toggle
   // crosses through flip-flops; the byte and word themselves are held still by the
   // link until the next frame, long after the system side has taken them. Two
   // commands closer together than about four system cycles would merge, which a
   // byte of eight link clocks can never cause.
   // Pen level and pen control mode come from outside and pass two flip-flops.
   logic [2:0] cmd_sync_q;
   logic [2:0] word_sync_q;
   logic [1:0] pen_sync_q;
   logic [1:0] pcm_sync_q;
   logic cmd_ev;
   logic word_ev;
   logic pen_down;
   logic pcm;
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cmd_sync_q <= 3'h0;
         word_sync_q <= 3'h0;
         pen_sync_q <= 2'h0;
         pcm_sync_q <= 2'h0;
      end else begin
         cmd_sync_q <= {cmd_sync_q[1:0], cmd_tgl_q};
         word_sync_q <= {word_sync_q[1:0], word_tgl_q};
         pen_sync_q <= {pen_sync_q[0], PEN_DOWN_IN};
         pcm_sync_q <= {pcm_sync_q[0], PEN_CONTROL_MODE_IN};
      end
   end
   assign cmd_ev = cmd_sync_q[2] ^ cmd_sync_q[1];
   assign word_ev = word_sync_q[2] ^ word_sync_q[1];
   assign pen_down = pen_sync_q[1];
   assign pcm = pcm_sync_q[1];

   // The command and word registers are stable for many system cycles after their toggle.
   logic [7:0] cmd;
   assign cmd = cmd_q;

   // ==========================================
   // Register access towards the register file.
   // Access bytes carry the address and bias bit; a read is requested at once so
   // that the word is ready before the host clocks it out, while a write waits for
   // its data word. Configuration register zero is read back with the live
   // resolution bit in place of the stored one, since both names hold one bit.
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         REG_ADDR_OUT <= 4'h0;
         REG_WDATA_OUT <= 16'h0000;
         REG_WR_OUT <= 1'b0;
         REG_RD_OUT <= 1'b0;
         rdata_hold_q <= 16'h0000;
         BIAS_KEEP_ON_OUT <= 1'b0;
      end else begin
         REG_WR_OUT <= 1'b0;
         REG_RD_OUT <= 1'b0;
         if (cmd_ev && !is_start_byte(cmd)) begin
            REG_ADDR_OUT <= code_field(cmd);
            BIAS_KEEP_ON_OUT <= cmd[`CB_BIAS_BIT];
            REG_RD_OUT <= cmd[`CB_DIR_BIT];
         end
         if (word_ev) begin
            REG_ADDR_OUT <= word_addr_q;
            REG_WDATA_OUT <= word_q;
            REG_WR_OUT <= 1'b1;
         end
         if (REG_RD_OUT) begin
            rdata_hold_q <= (REG_ADDR_OUT == `CONFIG_REGISTER_ZERO_ADDR) ?
               {REG_RDATA_IN[15:14], RESOLUTION_SELECT_OUT, REG_RDATA_IN[12:0]} :
               REG_RDATA_IN;
         end
      end
   end

   // ==========================================
   // Converter function control.
   logic [3:0] scan_code_q;
   logic scan_armed_q;
   logic test_fail_q;
   logic res_q;
   logic is_test;
   assign is_test = is_test_code(FUNCTION_SELECT_CODE_OUT);

   // A start byte is decoded in a fixed order: soft reset first, then stop, and only
   // then the function select code. This way a byte that asks for both a function
   // and a stop never starts the converter.
   // The stored scan code survives the end of a scan while pen control mode is one,
   // so a later touch restarts the same scan without a new byte from the host.
   // In host-controlled mode the arming is dropped at pen lift, and the host must
   // send the scan code again for the next touch.

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         FUNCTION_SELECT_CODE_OUT <= 4'h0;
         FUNC_START_OUT <= 1'b0;
         FUNC_BUSY_OUT <= 1'b0;
         CONT_MODE_OUT <= 1'b0;
         SOFT_RESET_OUT <= 1'b0;
         STOP_OUT <= 1'b0;
         res_q <= 1'b0;
         scan_code_q <= 4'h0;
         scan_armed_q <= 1'b0;
         test_fail_q <= 1'b0;
      end else begin
         FUNC_START_OUT <= 1'b0;
         if (cmd_ev && is_start_byte(cmd)) begin
            SOFT_RESET_OUT <= cmd[`CB_SRST_BIT];
            STOP_OUT <= cmd[`CB_STOP_BIT];
            res_q <= cmd[`CB_SRST_BIT] ? 1'b0 : cmd[`CB_RES_BIT];
            if (cmd[`CB_SRST_BIT]) begin
               FUNC_BUSY_OUT <= 1'b0;
               CONT_MODE_OUT <= 1'b0;
               scan_armed_q <= 1'b0;
               test_fail_q <= 1'b0;
            end else if (cmd[`CB_STOP_BIT]) begin
               FUNC_BUSY_OUT <= 1'b0;
               CONT_MODE_OUT <= 1'b0;
               test_fail_q <= 1'b0;
            end else begin
               FUNCTION_SELECT_CODE_OUT <= code_field(cmd);
               unique case (cmd[`CB_CODE_HI:`CB_CODE_LO])
                  `FN_SCAN_XYZ, `FN_SCAN_XY: begin
                     scan_code_q <= cmd[`CB_CODE_HI:`CB_CODE_LO];
                     scan_armed_q <= 1'b1;
                     CONT_MODE_OUT <= 1'b1;
                     FUNC_BUSY_OUT <= pen_down;
                     FUNC_START_OUT <= pen_down;
                  end
                  `FN_AUX_CONT: begin
                     CONT_MODE_OUT <= 1'b1;
                     FUNC_BUSY_OUT <= 1'b1;
                     FUNC_START_OUT <= 1'b1;
                  end
                  `FN_RESERVED: begin
                     FUNC_BUSY_OUT <= 1'b0;
                     CONT_MODE_OUT <= 1'b0;
                  end
                  default: begin
                     CONT_MODE_OUT <= 1'b0;
                     FUNC_BUSY_OUT <= 1'b1;
                     FUNC_START_OUT <= 1'b1;
                     test_fail_q <= 1'b0;
                  end
               endcase
            end
         end else if (!STOP_OUT && !SOFT_RESET_OUT) begin
            if (!FUNC_BUSY_OUT && scan_armed_q && pcm && pen_down) begin
               FUNCTION_SELECT_CODE_OUT <= scan_code_q;
               CONT_MODE_OUT <= 1'b1;
               FUNC_BUSY_OUT <= 1'b1;
               FUNC_START_OUT <= 1'b1;
            end else if (FUNC_BUSY_OUT && CONT_MODE_OUT &&
                         is_scan_code(FUNCTION_SELECT_CODE_OUT) && !pen_down) begin
               FUNC_BUSY_OUT <= 1'b0;
               scan_armed_q <= pcm;
            // A single conversion or test ends when the converter reports done; a failed
            // test latches so the interrupt pin stays low after the function ends.
            end else if (FUNC_BUSY_OUT && !CONT_MODE_OUT && FUNC_DONE_IN) begin
               FUNC_BUSY_OUT <= 1'b0;
               test_fail_q <= is_test && !TEST_PASS_IN;
            end
         end
      end
   end

   // ==========================================
   // Outputs derived from function state.
   // All outputs in this block are registered from the function state, so they
   // lag that state by one system cycle; a test failure keeps the interrupt pin low
   // after the test ends until a stop, soft reset or new single-function start byte clears the latch.
   // Bias is kept on between conversions only when the keep-on bit is set; without
   // it the bias follows the start pulse alone.
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         DRIVERS_OUT <= '0;
         PEN_DATA_INTERRUPT_PIN_OUT <= 1'b1;
         BIAS_ON_OUT <= 1'b0;
         ADC_POWER_OUT <= 1'b0;
         CONFIG_REGISTER_ZERO_STATUS_OUT <= 16'h4000;
         RESOLUTION_SELECT_OUT <= 1'b0;
      end else begin
         RESOLUTION_SELECT_OUT <= res_q;
         DRIVERS_OUT <= FUNC_BUSY_OUT ? drivers_for(FUNCTION_SELECT_CODE_OUT) : '0;
         PEN_DATA_INTERRUPT_PIN_OUT <= !((FUNC_BUSY_OUT && is_test) || test_fail_q);
         ADC_POWER_OUT <= FUNC_BUSY_OUT && !STOP_OUT;
         BIAS_ON_OUT <= FUNC_BUSY_OUT && !STOP_OUT &&
            (BIAS_KEEP_ON_OUT || FUNC_START_OUT);
         CONFIG_REGISTER_ZERO_STATUS_OUT <= {pen_down, !FUNC_BUSY_OUT, res_q, 13'h0000};
      end
   end
endmodule

// File: touch_ctrl_cfg.svh
// Constants for the touch controller control byte decoder.
`ifndef TOUCH_CTRL_CFG_SVH
`define TOUCH_CTRL_CFG_SVH
// ==========================================
// Control byte fields
`define CB_TYPE_BIT 7
`define CB_CODE_HI 6
`define CB_CODE_LO 3
`define CB_RES_BIT 2
`define CB_SRST_BIT 1
`define CB_STOP_BIT 0
`define CB_BIAS_BIT 1
`define CB_DIR_BIT 0
// ==========================================
// Function select codes
`define FN_SCAN_XYZ 4'h0
`define FN_SCAN_XY 4'h1
`define FN_X 4'h2
`define FN_Y 4'h3
`define FN_Z 4'h4
`define FN_AUX 4'h5
`define FN_TEMP1 4'h6
`define FN_TEMP2 4'h7
`define FN_AUX_CONT 4'h8
`define FN_TEST_X 4'h9
`define FN_TEST_Y 4'ha
`define FN_TEST_SHORT 4'hb
`define FN_RESERVED 4'hc
`define FN_DRV_X 4'hd
`define FN_DRV_Y 4'he
`define FN_DRV_YX 4'hf
// ==========================================
// Link framing and the configuration register zero address
`define BYTE_BITS 8
`define WORD_BITS 16
`define CONFIG_REGISTER_ZERO_ADDR 4'hc
`endif

// File: touch_ctrl_checker.sv
// Concurrent checks on the control byte decoder ports.
`timescale 1ns/1ps
`include "touch_ctrl_cfg.svh"
module touch_ctrl_checker (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic NRST_IN,
   // Watched ports
   input wire logic NCS_IN,
   input wire logic SDO_OE_OUT,
   input wire logic REG_WR_OUT,
   input wire logic REG_RD_OUT,
   input wire logic [3:0] FUNCTION_SELECT_CODE_OUT,
   input wire logic FUNC_START_OUT,
   input wire logic FUNC_BUSY_OUT,
   input wire logic RESOLUTION_SELECT_OUT,
   input wire logic SOFT_RESET_OUT,
   input wire logic STOP_OUT,
   input wire logic ADC_POWER_OUT,
   input wire logic [15:0] CONFIG_REGISTER_ZERO_STATUS_OUT,
   input wire logic PEN_DATA_INTERRUPT_PIN_OUT
);
   // ==========================================
   // Properties
   default clocking @(posedge MCLK_IN);
   endclocking
   default disable iff (!NRST_IN);
   sequence s_stop_held;
      STOP_OUT ##1 STOP_OUT;
   endsequence
   sequence s_testing;
      FUNC_BUSY_OUT && (FUNCTION_SELECT_CODE_OUT inside
         {`FN_TEST_X, `FN_TEST_Y, `FN_TEST_SHORT}) ##1 FUNC_BUSY_OUT;
   endsequence
   a_start_one_shot: assert property (FUNC_START_OUT |=> !FUNC_START_OUT)
      else $error("start pulse too long");
   a_write_one_shot: assert property (REG_WR_OUT |=> !REG_WR_OUT)
      else $error("write pulse too long");
   a_read_not_write: assert property (REG_RD_OUT |-> !REG_WR_OUT)
      else $error("read and write together");
   a_test_pin_low: assert property (s_testing |-> !PEN_DATA_INTERRUPT_PIN_OUT)
      else $error("pin high during test");
   a_res_mirror: assert property ((RESOLUTION_SELECT_OUT != CONFIG_REGISTER_ZERO_STATUS_OUT[13])
      |-> ##[1:2] (RESOLUTION_SELECT_OUT == CONFIG_REGISTER_ZERO_STATUS_OUT[13])) else $error("status res lags");
   a_stop_aborts: assert property ($rose(STOP_OUT) |-> ##[0:2] !FUNC_BUSY_OUT)
      else $error("busy after stop");
   a_stop_powers_down: assert property (s_stop_held |-> !ADC_POWER_OUT && !FUNC_START_OUT)
      else $error("converter live in stop");
   a_stop_frees_pin: assert property (s_stop_held ##1 STOP_OUT |-> PEN_DATA_INTERRUPT_PIN_OUT)
      else $error("pin low in stop");
   a_srst_defaults: assert property (SOFT_RESET_OUT ##1 SOFT_RESET_OUT
      |-> !RESOLUTION_SELECT_OUT && !FUNC_BUSY_OUT) else $error("state kept in soft reset");
   a_sdo_quiet: assert property (NCS_IN |-> !SDO_OE_OUT)
      else $error("sdo driven while deselected");
endmodule
bind touch_ctrl_byte_decoder touch_ctrl_checker touch_ctrl_checker_i (
   .MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .NCS_IN(NCS_IN), .SDO_OE_OUT(SDO_OE_OUT),
   .REG_WR_OUT(REG_WR_OUT), .REG_RD_OUT(REG_RD_OUT), .FUNC_START_OUT(FUNC_START_OUT),
   .FUNCTION_SELECT_CODE_OUT(FUNCTION_SELECT_CODE_OUT), .FUNC_BUSY_OUT(FUNC_BUSY_OUT),
   .RESOLUTION_SELECT_OUT(RESOLUTION_SELECT_OUT), .SOFT_RESET_OUT(SOFT_RESET_OUT),
   .STOP_OUT(STOP_OUT), .ADC_POWER_OUT(ADC_POWER_OUT), .CONFIG_REGISTER_ZERO_STATUS_OUT(CONFIG_REGISTER_ZERO_STATUS_OUT),
   .PEN_DATA_INTERRUPT_PIN_OUT(PEN_DATA_INTERRUPT_PIN_OUT)
);

// File: touch_ctrl_pkg.sv
// Types for the touch controller control byte decoder.
package touch_ctrl_pkg;
   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_WORD = 2'b01
   } phase_type;
   typedef struct packed {
      logic is_read;
      logic [3:0] addr;
      logic [15:0] data;
   } reg_xfer_type;
   typedef struct packed {
      logic x_pos;
      logic x_neg;
      logic y_pos;
      logic y_neg;
   } drivers_type;
endpackage
